/* shared/val_pkg.sv */
/*
  Constants, timing figures and option encodings for the vehicle alarm and
  lock controller. Assumes a single 10 MHz system clock.
*/
package val_pkg;
  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned TICK_US      = 1000;
  // prescaler divides the system clock down to a 1 ms tick
  localparam int unsigned PRESC_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam logic [15:0] PRESC_LAST   = 16'(PRESC_CYCLES - 1);

  localparam int unsigned TRIG_HOLD_S  = 30;
  localparam int unsigned VOL_DELAY_S  = 15;
  localparam int unsigned DOUBLE_WIN_S = 1;
  localparam int unsigned MIS_ON_MS    = 50;
  localparam int unsigned MIS_OFF_MS   = 200;
  localparam int unsigned MIS_REPEATS  = 3;

  localparam logic [15:0] TRIG_HOLD_MS  = 16'(TRIG_HOLD_S * 1000);
  localparam logic [15:0] VOL_DELAY_MS  = 16'(VOL_DELAY_S * 1000);
  localparam logic [15:0] DOUBLE_WIN_MS = 16'(DOUBLE_WIN_S * 1000);
  localparam logic [15:0] MIS_ON_T      = 16'(MIS_ON_MS);
  localparam logic [15:0] MIS_OFF_T     = 16'(MIS_OFF_MS);
  localparam logic [1:0]  MIS_COUNT     = 2'(MIS_REPEATS);

  // super locking options
  localparam logic [1:0] SL_NONE       = 2'h0;
  localparam logic [1:0] SL_HANDSET_1  = 2'h1;
  localparam logic [1:0] SL_SINGLE     = 2'h2;
  localparam logic [1:0] SL_DOUBLE     = 2'h3;

  // mislock output options
  localparam logic [2:0] MIS_NONE      = 3'h0;
  localparam logic [2:0] MIS_SOUNDER   = 3'h1;
  localparam logic [2:0] MIS_HORN      = 3'h2;
  localparam logic [2:0] MIS_SND_HORN  = 3'h3;
  localparam logic [2:0] MIS_BACKUP    = 3'h4;
  localparam logic [2:0] MIS_ALL       = 3'h5;

  typedef enum logic [1:0] {
    VAL_DISARMED,
    VAL_ARMED,
    VAL_TRIGGERED
  } val_alarm_type;
endpackage

/* rtl/val_timer.sv */
/*
  Millisecond down-counter. Loads on start, counts on each tick, pulses done
  on the tick that finds it at one or below. Assumes tick is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/1ns
module val_timer
  import val_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [15:0] load,
  output logic             running,
  output logic             done
);
  logic [15:0] count;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count   <= 16'h0000;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start) begin
        count   <= load;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (count <= 16'h0001) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count <= count - 16'h0001;
        end
      end
    end
  end
endmodule

/* rtl/val_sync.sv */
/*
  Two-flop synchroniser bank for the switch and sensor pins.
  Assumes pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ns
module val_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta     <= pin_in;
      sync_out <= meta;
    end
  end
endmodule

/* rtl/val_controller.sv */
/*
  Vehicle alarm and lock controller: crash unlock, internal lock switches,
  fuel flap gating, perimetric and volumetric alarm, super locking, partial
  arming and mislock warning. Assumes handset and key requests are one-cycle
  pulses from decoding logic on sys_clk; switch pins are asynchronous.
*/
`timescale 1ns/1ns
// Operation
// (R1) crash switch, disarmed, ignition on: unlock all
// (R2) crash also cuts pump, engine; optional indicators
// (R3) internal unlock ignored while super locked
// (R4) fuel flap only disarmed, ignition off, option key
// (R5) perimetric arms on lock if conditions met
// (R6) armed perimetric triggers on door or bonnet
// (R7) triggered state held thirty seconds then resets
// (R8) disarm option: always, or key-only after key lock
// (R9) volumetric arms fifteen seconds after lock
// (R10) volumetric arming conditions; sensor detection triggers
// (R11) super lock: four configurations
// (R12) double press within one second
// (R13) super lock needs doors closed, ignition off, uncrashed
// (R14) partial arm completes fifteen seconds after closing; closing before the lock delay ends completes at that delay's end
// (R15) bonnet open: super lock, volumetric, wait bonnet
// (R16) other door open: withhold super lock, volumetric
// (R17) shorted latch treated as open door
// (R18) open-circuit latch treated as closed door
// (R19) mislock when lock fails on open panel
// (R20) mislock output selects one of six options
// (R21) mislock pulses 50 ms on, 200 ms off, thrice
// (R22) full lock validity conditions
// (R23) intervals from prescaler and timers, reset cleared
module val_controller
  import val_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // pins (asynchronous)
  input  wire logic       driver_door_open,
  input  wire logic       other_door_open,
  input  wire logic       latch_short,
  input  wire logic       bonnet_open,
  input  wire logic       crash_tripped,
  input  wire logic       ignition_on,
  input  wire logic       key_inserted,
  input  wire logic       vol_sensor,
  input  wire logic       int_lock_sw,
  input  wire logic       int_unlock_sw,
  input  wire logic       flap_button,
  // decoded requests, one-cycle pulses on sys_clk
  input  wire logic       handset_lock,
  input  wire logic       handset_unlock,
  input  wire logic       key_lock,
  input  wire logic       key_unlock,
  input  wire logic       emergency_code_entry,
  // configuration
  input  wire logic       cfg_perimetric_en,
  input  wire logic       cfg_volumetric_en,
  input  wire logic       cfg_key_only_disarm,
  input  wire logic       cfg_flap_need_key_out,
  input  wire logic       cfg_crash_indicators,
  input  wire logic [1:0] cfg_superlock,
  input  wire logic [2:0] cfg_mislock,
  // outputs
  output logic            lock_doors,
  output logic            unlock_doors,
  output logic            super_locked,
  output logic            fuel_flap_release,
  output logic            fuel_pump_off,
  output logic            engine_controller_disable,
  output logic            indicators_flash,
  output logic            alarm_sounder,
  output logic            horn,
  output logic            backup_sounder,
  output logic            peri_armed,
  output logic            vol_armed,
  output logic            partial_armed,
  output logic            alarm_triggered
);
  localparam int NPIN = 11;

  logic [NPIN-1:0] pins_s;
  logic drv_open, oth_raw, lshort, bon_open, crash, ign, key_in;
  logic vol_det, ilock, iunlock, flap_btn;
  logic crash_q, ilock_q, iunlock_q;
  logic tick;
  logic [15:0] presc;
  logic oth_open, any_lock, any_unlock;
  logic lock_ok, sl_ok, sl_req, disarm_ok;
  logic locked_by_key, first_press, first_key;
  logic mis_busy, mis_on;
  logic [1:0] mis_left;
  logic trig_done, vol_done, dbl_run, mis_done;
  logic trig_start, vol_start, dbl_start, mis_start;
  logic [15:0] mis_load;
  logic vol_pending, next_vol_pending;
  val_alarm_type state;

  val_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .pin_in  ({driver_door_open, other_door_open, latch_short,
               bonnet_open, crash_tripped, ignition_on, key_inserted,
               vol_sensor, int_lock_sw, int_unlock_sw, flap_button}),
    .sync_out(pins_s)
  );

  assign {drv_open, oth_raw, lshort, bon_open, crash, ign, key_in,
          vol_det, ilock, iunlock, flap_btn} = pins_s;

  // an open-circuit harness reads as closed, so only a short counts
  assign oth_open   = oth_raw | lshort;                       // (R17) (R18)
  assign any_lock   = handset_lock | key_lock;
  assign any_unlock = handset_unlock | key_unlock;

  function automatic logic panels_closed(input logic d, input logic o,
                                         input logic b);
    panels_closed = !d && !o && !b;
  endfunction

  assign lock_ok = !drv_open && !ign && !crash && !bon_open
                   && !super_locked;                          // (R22)
  assign sl_ok   = panels_closed(drv_open, oth_open, bon_open)
                   && !ign && !crash;                         // (R13)

  // (R23)
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      presc <= 16'h0000;
      tick  <= 1'b0;
    end else if (clk_en) begin
      tick <= (presc == PRESC_LAST);
      if (presc == PRESC_LAST) begin
        presc <= 16'h0000;
      end else begin
        presc <= presc + 16'h0001;
      end
    end
  end

  val_timer u_trig (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .tick(tick),
    .start  (trig_start), .stop(state == VAL_DISARMED),
    .load   (TRIG_HOLD_MS),
    .running(), .done(trig_done)
  );
  val_timer u_vol (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .tick(tick),
    .start  (vol_start), .stop(any_unlock), .load(VOL_DELAY_MS),
    .running(), .done(vol_done)
  );
  val_timer u_dbl (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .tick(tick),
    .start  (dbl_start), .stop(any_unlock), .load(DOUBLE_WIN_MS),
    .running(dbl_run), .done()
  );
  val_timer u_mis (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .tick(tick),
    .start  (mis_start), .stop(1'b0), .load(mis_load),
    .running(), .done(mis_done)
  );

  // crash, internal switch edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      crash_q   <= 1'b0;
      ilock_q   <= 1'b0;
      iunlock_q <= 1'b0;
    end else if (clk_en) begin
      crash_q   <= crash;
      ilock_q   <= ilock;
      iunlock_q <= iunlock;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unlock_doors <= 1'b0;
      lock_doors   <= 1'b0;
    end else if (clk_en) begin
      unlock_doors <= 1'b0;
      lock_doors   <= 1'b0;
      if (crash && !crash_q && state == VAL_DISARMED && ign) begin
        unlock_doors <= 1'b1;                                 // (R1)
      end else if (iunlock && !iunlock_q && !super_locked) begin
        unlock_doors <= 1'b1;                                 // (R3)
      end else if (any_unlock && disarm_ok) begin
        unlock_doors <= 1'b1;
      end else if ((ilock && !ilock_q) || (any_lock && lock_ok)) begin
        lock_doors <= 1'b1;                                   // (R22)
      end
    end
  end

  // crash outcome latched until reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fuel_pump_off             <= 1'b0;
      engine_controller_disable <= 1'b0;
      indicators_flash          <= 1'b0;
    end else if (clk_en) begin
      if (crash && !crash_q && state == VAL_DISARMED && ign) begin
        fuel_pump_off             <= 1'b1;                    // (R2)
        engine_controller_disable <= 1'b1;                    // (R2)
        indicators_flash          <= cfg_crash_indicators;    // (R2)
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fuel_flap_release <= 1'b0;
    end else if (clk_en) begin
      fuel_flap_release <= flap_btn && state == VAL_DISARMED && !ign
                           && !(cfg_flap_need_key_out && key_in); // (R4)
    end
  end

  // handset unlock is refused after a key lock in key-only mode
  assign disarm_ok = key_unlock || emergency_code_entry
                     || (handset_unlock
                         && !(cfg_key_only_disarm && locked_by_key)); // (R8)

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      locked_by_key <= 1'b0;
    end else if (clk_en) begin
      if (key_lock) begin
        locked_by_key <= 1'b1;
      end else if (handset_lock || (any_unlock && disarm_ok)) begin
        locked_by_key <= 1'b0;
      end
    end
  end

  // alarm state; arming conditions exclude bonnet and other doors
  assign trig_start = (state == VAL_ARMED) && (
                        (peri_armed && (drv_open || (!partial_armed
                         && (oth_open || bon_open))))         // (R6)
                      || (vol_armed && vol_det));             // (R10)

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= VAL_DISARMED;
    end else if (clk_en) begin
      case (state)
        VAL_DISARMED: begin
          if (any_lock && !drv_open && !key_in && !crash
              && (cfg_perimetric_en || cfg_volumetric_en)) begin
            state <= VAL_ARMED;                               // (R5)
          end
        end
        VAL_ARMED: begin
          if (emergency_code_entry || (any_unlock && disarm_ok)) begin
            state <= VAL_DISARMED;                            // (R8)
          end else if (trig_start) begin
            state <= VAL_TRIGGERED;
          end
        end
        VAL_TRIGGERED: begin
          if (emergency_code_entry || (any_unlock && disarm_ok)) begin
            state <= VAL_DISARMED;
          end else if (trig_done) begin
            state <= VAL_ARMED;                               // (R7)
          end
        end
        default: state <= VAL_DISARMED;
      endcase
    end
  end

  assign alarm_triggered = (state == VAL_TRIGGERED);

  // partial arming: wait for panels, then restart the 15 s delay if none is still pending
  assign vol_start = ((state == VAL_DISARMED) && any_lock && !drv_open
                      && !key_in && !crash)                   // (R9)
                   || (partial_armed && !oth_open && !bon_open
                       && !vol_pending);                      // (R14)

  always_comb begin
    next_vol_pending = vol_pending;
    if (state == VAL_DISARMED || vol_done) begin
      next_vol_pending = 1'b0;
    end
    if (vol_start) begin
      next_vol_pending = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vol_pending   <= 1'b0;
      peri_armed    <= 1'b0;
      vol_armed     <= 1'b0;
      partial_armed <= 1'b0;
    end else if (clk_en) begin
      vol_pending <= next_vol_pending;
      if (state == VAL_DISARMED) begin
        peri_armed    <= 1'b0;
        vol_armed     <= 1'b0;
        partial_armed <= 1'b0;
        if (vol_start) begin
          peri_armed    <= cfg_perimetric_en;                 // (R5)
          partial_armed <= oth_open || bon_open;
        end
      end else begin
        if (partial_armed && !oth_open && !bon_open && vol_done) begin
          partial_armed <= 1'b0;                              // (R14)
          peri_armed    <= cfg_perimetric_en;
        end
        // bonnet-only partial arming still runs volumetric sensing
        if (vol_done && cfg_volumetric_en && !oth_open) begin
          vol_armed <= 1'b1;                                  // (R10) (R15)
        end
        if (oth_open) begin
          vol_armed <= 1'b0;                                  // (R16)
        end
      end
    end
  end

  // super locking
  always_comb begin
    case (cfg_superlock)
      SL_HANDSET_1: sl_req = handset_lock;
      SL_SINGLE:    sl_req = any_lock;
      SL_DOUBLE:    sl_req = (handset_lock && dbl_run && first_press)
                           || (key_lock && dbl_run && first_key); // (R12)
      default:      sl_req = 1'b0;
    endcase
  end

  assign dbl_start = any_lock && !dbl_run;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      first_press <= 1'b0;
      first_key   <= 1'b0;
    end else if (clk_en) begin
      if (dbl_start) begin
        first_press <= handset_lock;
        first_key   <= key_lock;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      super_locked <= 1'b0;
    end else if (clk_en) begin
      if (any_unlock && disarm_ok) begin
        super_locked <= 1'b0;
      end else if (sl_req && !oth_open && !drv_open && !ign
                   && !crash) begin
        super_locked <= 1'b1;                                 // (R11) (R13) (R15)
      end else if (super_locked == 1'b0 && partial_armed
                   && !oth_open && cfg_superlock != SL_NONE
                   && sl_ok) begin
        super_locked <= 1'b1;                                 // (R16)
      end
    end
  end

  // mislock: lock request fails on an open door or bonnet
  assign mis_start = (any_lock && (drv_open || oth_open || bon_open)
                      && !mis_busy && cfg_mislock != MIS_NONE)  // (R19)
                   || (mis_busy && mis_done
                       && !(mis_on == 1'b0 && mis_left == 2'h0));
  assign mis_load  = (mis_busy && mis_on) ? MIS_OFF_T : MIS_ON_T; // (R21)

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mis_busy <= 1'b0;
      mis_on   <= 1'b0;
      mis_left <= 2'h0;
    end else if (clk_en) begin
      if (!mis_busy && mis_start) begin
        mis_busy <= 1'b1;
        mis_on   <= 1'b1;
        mis_left <= MIS_COUNT - 2'h1;
      end else if (mis_busy && mis_done) begin
        if (mis_on) begin
          mis_on <= 1'b0;                                     // (R21)
        end else if (mis_left == 2'h0) begin
          mis_busy <= 1'b0;
        end else begin
          mis_on   <= 1'b1;
          mis_left <= mis_left - 2'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alarm_sounder  <= 1'b0;
      horn           <= 1'b0;
      backup_sounder <= 1'b0;
    end else if (clk_en) begin
      alarm_sounder  <= alarm_triggered || (mis_on && mis_busy
                        && (cfg_mislock == MIS_SOUNDER
                         || cfg_mislock == MIS_SND_HORN
                         || cfg_mislock == MIS_ALL));          // (R20)
      horn           <= mis_on && mis_busy
                        && (cfg_mislock == MIS_HORN
                         || cfg_mislock == MIS_SND_HORN
                         || cfg_mislock == MIS_ALL);           // (R20)
      backup_sounder <= alarm_triggered || (mis_on && mis_busy
                        && (cfg_mislock == MIS_BACKUP
                         || cfg_mislock == MIS_ALL));          // (R20)
    end
  end
endmodule

/* verification/val_controller_props.sv */
/*
  Checker for the alarm and lock controller, watching top-level ports.
  Assumes clk_en stays high and pins pass a two-flop synchroniser.
*/
`timescale 1ns/1ns
module val_controller_props
  import val_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       handset_lock,
  input wire logic       key_lock,
  input wire logic       handset_unlock,
  input wire logic       key_unlock,
  input wire logic       emergency_code_entry,
  input wire logic       driver_door_open,
  input wire logic       other_door_open,
  input wire logic       latch_short,
  input wire logic       bonnet_open,
  input wire logic       crash_tripped,
  input wire logic       ignition_on,
  input wire logic       key_inserted,
  input wire logic       cfg_perimetric_en,
  input wire logic [2:0] cfg_mislock,
  input wire logic       unlock_doors,
  input wire logic       super_locked,
  input wire logic       fuel_flap_release,
  input wire logic       fuel_pump_off,
  input wire logic       engine_controller_disable,
  input wire logic       horn,
  input wire logic       peri_armed,
  input wire logic       vol_armed,
  input wire logic       alarm_triggered
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_crash_unlock;
    ignition_on[*3] ##0 ($rose(crash_tripped) && !peri_armed && !vol_armed)
      |-> ##[1:4] unlock_doors;
  endproperty
  a_crash_unlock: assert property (p_crash_unlock)
    else $error("crash did not unlock doors");

  property p_crash_engine;
    $rose(fuel_pump_off) |-> engine_controller_disable;
  endproperty
  a_crash_engine: assert property (p_crash_engine)
    else $error("pump cut without engine disable");

  // other unlock sources kept quiet across the window
  property p_int_unlock;
    (super_locked && !handset_unlock && !key_unlock && !emergency_code_entry
      && !crash_tripped)[*4] |-> !unlock_doors;
  endproperty
  a_int_unlock: assert property (p_int_unlock)
    else $error("unlock while super locked");

  property p_flap;
    (ignition_on || peri_armed)[*4] |-> !fuel_flap_release;
  endproperty
  a_flap: assert property (p_flap)
    else $error("flap released while armed or ignition on");

  property p_arm;
    (!driver_door_open && !other_door_open && !latch_short && !bonnet_open
      && !crash_tripped && !ignition_on && !key_inserted)[*3]
      ##0 ((handset_lock || key_lock) && cfg_perimetric_en && !peri_armed
      && !alarm_triggered) |-> ##[1:3] peri_armed;
  endproperty
  a_arm: assert property (p_arm)
    else $error("perimetric alarm failed to arm");

  property p_trigger;
    peri_armed && $rose(bonnet_open) |-> ##[1:5] alarm_triggered;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("open bonnet did not trigger");

  property p_trig_hold;
    $rose(alarm_triggered) |=> alarm_triggered[*8];
  endproperty
  a_trig_hold: assert property (p_trig_hold)
    else $error("triggered state dropped early");

  property p_sl_cond;
    (ignition_on || crash_tripped)[*4] |-> !$rose(super_locked);
  endproperty
  a_sl_cond: assert property (p_sl_cond)
    else $error("super locked with ignition on or crash");

  property p_mislock;
    driver_door_open[*3] ##0 (handset_lock && (cfg_mislock == MIS_HORN
      || cfg_mislock == MIS_SND_HORN || cfg_mislock == MIS_ALL))
      |-> ##[1:3] horn;
  endproperty
  a_mislock: assert property (p_mislock)
    else $error("mislock warning did not start");

  c_armed: cover property ($rose(peri_armed));
  c_trig: cover property ($rose(alarm_triggered));
  c_super: cover property ($rose(super_locked));
endmodule

bind val_controller val_controller_props u_props (.*);

/* verification/val_partner.sv */
/*
  Far side model: door, bonnet, sensor and switch pins plus handset and
  key request pulses. Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ns
module val_partner (
  input  wire logic        sys_clk,
  output logic      [10:0] pin,
  output logic      [4:0]  req
);
  initial begin
    pin = 11'h000;
    req = 5'h00;
  end

  task set_pin(input int i, input logic v);
    @(posedge sys_clk);
    pin[i] <= v;
  endtask

  // receiver decodes one frame into a single-cycle request
  task press(input int i);
    @(posedge sys_clk);
    req[i] <= 1'b1;
    @(posedge sys_clk);
    req <= 5'h00;
  endtask
endmodule

/* verification/val_controller_tb.sv */
/*
  Self-checking bench for the alarm and lock controller.
  Assumes the partner model and the bound checker; long timers untouched.
*/
`timescale 1ns/1ns
module val_controller_tb;
  import val_pkg::*;
  localparam int DRV = 0, OTH = 1, BON = 3, CRA = 4, IGN = 5, KEY = 6;
  localparam int IUL = 9, FLP = 10;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [4:0] cfg = 5'h00;
  logic [1:0] sl = 2'h0;
  logic [2:0] mis = 3'h0;
  logic [10:0] pin;
  logic [4:0] req;
  logic lock_doors, unlock_doors, super_locked, fuel_flap_release;
  logic fuel_pump_off, engine_controller_disable, indicators_flash;
  logic alarm_sounder, horn, backup_sounder, peri_armed, vol_armed;
  logic partial_armed, alarm_triggered;
  logic seen_ul = 1'b0;
  int fails = 0, check_count = 0, cycles = 0;

  always #50 sys_clk = ~sys_clk;

  val_partner bfm (.sys_clk, .pin, .req);

  val_controller dut (
    .sys_clk, .rst, .clk_en,
    .driver_door_open(pin[0]), .other_door_open(pin[1]),
    .latch_short(pin[2]), .bonnet_open(pin[3]), .crash_tripped(pin[4]),
    .ignition_on(pin[5]), .key_inserted(pin[6]), .vol_sensor(pin[7]),
    .int_lock_sw(pin[8]), .int_unlock_sw(pin[9]), .flap_button(pin[10]),
    .handset_lock(req[0]), .handset_unlock(req[1]), .key_lock(req[2]),
    .key_unlock(req[3]), .emergency_code_entry(req[4]),
    .cfg_perimetric_en(cfg[0]), .cfg_volumetric_en(cfg[1]),
    .cfg_key_only_disarm(cfg[2]), .cfg_flap_need_key_out(cfg[3]),
    .cfg_crash_indicators(cfg[4]), .cfg_superlock(sl), .cfg_mislock(mis),
    .lock_doors, .unlock_doors, .super_locked, .fuel_flap_release,
    .fuel_pump_off, .engine_controller_disable, .indicators_flash,
    .alarm_sounder, .horn, .backup_sounder, .peri_armed, .vol_armed,
    .partial_armed, .alarm_triggered
  );

  // unlock is a one-cycle pulse, so latch it for later inspection
  always @(posedge sys_clk) begin
    if (unlock_doors === 1'b1) seen_ul <= 1'b1;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic start(input logic [4:0] c, input logic [1:0] s,
                       input logic [2:0] m);
    @(posedge sys_clk);
    rst <= 1'b1;
    cfg <= c;
    sl <= s;
    mis <= m;
    bfm.pin <= 11'h000;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(3);
    seen_ul = 1'b0;
  endtask

  task automatic t_crash;
    start(5'h10, SL_NONE, MIS_NONE);
    chk(fuel_pump_off, 1'b0);
    bfm.set_pin(IGN, 1'b1);
    cyc(3);
    bfm.set_pin(CRA, 1'b1);
    cyc(6);
    chk(seen_ul, 1'b1);
    chk(fuel_pump_off, 1'b1);
    chk(engine_controller_disable, 1'b1);
    chk(indicators_flash, 1'b1);
    $display("test crash done");
  endtask

  task automatic t_flap;
    start(5'h00, SL_NONE, MIS_NONE);
    bfm.set_pin(FLP, 1'b1);
    cyc(5);
    chk(fuel_flap_release, 1'b1);
    bfm.set_pin(IGN, 1'b1);
    cyc(5);
    chk(fuel_flap_release, 1'b0);
    start(5'h08, SL_NONE, MIS_NONE);
    bfm.set_pin(KEY, 1'b1);
    bfm.set_pin(FLP, 1'b1);
    cyc(5);
    chk(fuel_flap_release, 1'b0);
    $display("test flap done");
  endtask

  task automatic t_arm;
    start(5'h01, SL_NONE, MIS_NONE);
    bfm.press(0);
    cyc(4);
    chk(peri_armed, 1'b1);
    bfm.set_pin(BON, 1'b1);
    cyc(6);
    chk(alarm_triggered, 1'b1);
    bfm.set_pin(IGN, 1'b1);
    bfm.set_pin(CRA, 1'b1);
    cyc(6);
    chk(seen_ul, 1'b0);
    chk(alarm_triggered, 1'b1);
    $display("test arm done");
  endtask

  // every mislock output option with the driver door left open
  task automatic t_mislock;
    for (int m = 0; m < 6; m++) begin
      start(5'h01, SL_NONE, 3'(m));
      bfm.set_pin(DRV, 1'b1);
      cyc(3);
      bfm.press(0);
      cyc(4);
      chk(peri_armed, 1'b0);
      chk(alarm_sounder, m == 1 || m == 3 || m == 5);
      chk(horn, m == 2 || m == 3 || m == 5);
      chk(backup_sounder, m >= 4);
    end
    $display("test mislock done");
  endtask

  task automatic t_super;
    logic [1:0] sc [5] = '{SL_NONE, SL_HANDSET_1, SL_HANDSET_1, SL_SINGLE,
                           SL_DOUBLE};
    int rq [5] = '{0, 0, 2, 2, 0};
    logic ex [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      start(5'h01, sc[i], MIS_NONE);
      bfm.press(rq[i]);
      cyc(6);
      chk(super_locked, ex[i]);
    end
    bfm.press(0);
    cyc(6);
    chk(super_locked, 1'b1);
    seen_ul = 1'b0;
    bfm.set_pin(IUL, 1'b1);
    cyc(6);
    chk(seen_ul, 1'b0);
    start(5'h01, SL_HANDSET_1, MIS_NONE);
    bfm.set_pin(OTH, 1'b1);
    cyc(3);
    bfm.press(0);
    cyc(6);
    chk(super_locked, 1'b0);
    chk(peri_armed, 1'b1);
    chk(partial_armed, 1'b1);
    chk(alarm_triggered, 1'b0);
    $display("test super done");
  endtask

  task automatic t_disarm;
    start(5'h05, SL_NONE, MIS_NONE);
    bfm.press(2);
    cyc(4);
    chk(peri_armed, 1'b1);
    bfm.press(1);
    cyc(4);
    chk(seen_ul, 1'b0);
    chk(peri_armed, 1'b1);
    bfm.press(3);
    cyc(4);
    chk(peri_armed, 1'b0);
    $display("test disarm done");
  endtask

  initial begin
    t_crash();
    t_flap();
    t_arm();
    t_mislock();
    t_super();
    t_disarm();
    test_done();
  end
endmodule
